// ---- src/gpp_pkg.sv ----
// Package of register map, field positions and reset values for the GPIO port
package gpp_pkg;

  localparam int          PORT_WIDTH          = 8;            // Pins per port
  localparam int          ADDR_WIDTH          = 5;            // Byte address bits decoded
  localparam logic [4:0]  OUTPUT_REG_ADDR     = 5'h00;        // output_register
  localparam logic [4:0]  DIRECTION_REG_ADDR  = 5'h04;        // direction_register
  localparam logic [4:0]  INPUT_REG_ADDR      = 5'h08;        // input_register
  localparam logic [4:0]  MCU_CONTROL_ADDR    = 5'h0c;        // mcu_control_register
  localparam logic [4:0]  OVERRIDE_REG_ADDR   = 5'h10;        // Drive override enable (7:0), value (15:8)
  localparam logic [4:0]  WAKE_FLAG_ADDR      = 5'h14;        // Wake-up flags, write one to clear
  localparam int          PUD_BIT             = 4;            // global_pullup_off position
  localparam logic [7:0]  PORT_RESET          = 8'h00;        // Latch and direction after reset
  localparam logic [1:0]  RESP_OKAY           = 2'h0;         // AXI OKAY
  localparam logic [1:0]  RESP_SLVERR         = 2'h2;         // AXI SLVERR for unmapped

endpackage : gpp_pkg

// ---- src/gpp_port.sv ----
// GPIO port: pad control, input synchroniser, sleep clamp and AXI4-Lite registers
`timescale 1ns/100ps

// Contract
// - Single-bit writes leave other pins unchanged
// - Direction bit one drives pad as output
// - Input with latch one gets pull-up
// - Latch zero or output turns pull-up off
// - Reset tri-states every pad without clock
// - Output pad follows latch level
// - Writing one to input register toggles latch
// - Global pull-up off disables all pull-ups
// - Three port registers, input read-only
// - Input sample readable in any direction
// - High-transparent latch then rising flop
// - Written output readable one cycle later
// - Sleep clamp grounds digital input path
// - Enabled external interrupt pads escape clamp
// - Clamp release sets flag on high pad, only if edge-sensed with its interrupt disabled
// - Pull-ups off while reset active
// - Alternate function affects only its pads
// - Drive override replaces direction bit
// - Global pull-up off at control bit 4
module gpp_port
  import gpp_pkg::*;
(
  input  wire logic                    i_clock,
  input  wire logic                    i_arst_n,
  input  wire logic                    i_clk_en,
  // AXI4-Lite slave
  input  wire logic [ADDR_WIDTH-1:0]   i_awaddr,
  input  wire logic                    i_awvalid,
  output logic                         o_awready,
  input  wire logic [31:0]             i_wdata,
  input  wire logic [3:0]              i_wstrb,
  input  wire logic                    i_wvalid,
  output logic                         o_wready,
  output logic [1:0]                   o_bresp,
  output logic                         o_bvalid,
  input  wire logic                    i_bready,
  input  wire logic [ADDR_WIDTH-1:0]   i_araddr,
  input  wire logic                    i_arvalid,
  output logic                         o_arready,
  output logic [31:0]                  o_rdata,
  output logic [1:0]                   o_rresp,
  output logic                         o_rvalid,
  input  wire logic                    i_rready,
  // Pads
  input  wire logic [PORT_WIDTH-1:0]   i_pad,
  output logic [PORT_WIDTH-1:0]        o_pad,
  output logic [PORT_WIDTH-1:0]        o_pad_oe,
  output logic [PORT_WIDTH-1:0]        o_pullup_en,
  // Sleep controller and external interrupt context
  input  wire logic                    i_input_clamp_request,
  input  wire logic [PORT_WIDTH-1:0]   i_ext_irq_enabled,
  input  wire logic [PORT_WIDTH-1:0]   i_ext_irq_edge_sense,
  output logic [PORT_WIDTH-1:0]        o_wake_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [PORT_WIDTH-1:0] latch_reg;         // pin_output_latch_bit per pin
  logic [PORT_WIDTH-1:0] dir_reg;           // pin_direction_bit per pin
  logic                  pud_reg;           // global_pullup_off
  logic [PORT_WIDTH-1:0] ovr_en_reg;        // drive_override_enable per pin
  logic [PORT_WIDTH-1:0] ovr_val_reg;       // drive_override_value per pin
  logic [PORT_WIDTH-1:0] sample_reg;        // pin_input_sample_bit
  logic [PORT_WIDTH-1:0] sync_latch;        // Half-cycle synchroniser stage
  logic [PORT_WIDTH-1:0] wake_reg;          // Wake-up flags
  logic                  clamp_reg;         // Clamp state seen last cycle
  logic                  release_reg;       // Clamp dropped at the last edge

  // AXI write channel capture
  logic                  aw_have_reg;       // Address held
  logic                  w_have_reg;        // Data held
  logic [ADDR_WIDTH-1:0] aw_addr_reg;       // Captured write address
  logic [31:0]           w_data_reg;        // Captured write data
  logic [3:0]            w_strb_reg;        // Captured strobes

  ////////////////////////////////////////////////////////////////////////////
  // Address decode used by both channels
  function automatic logic addr_mapped(input logic [ADDR_WIDTH-1:0] a);
    addr_mapped = (a == OUTPUT_REG_ADDR) || (a == DIRECTION_REG_ADDR) ||
                  (a == INPUT_REG_ADDR) || (a == MCU_CONTROL_ADDR) ||
                  (a == OVERRIDE_REG_ADDR) || (a == WAKE_FLAG_ADDR);
  endfunction : addr_mapped

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: accept address and data in either order
  logic do_write;                           // Both halves present, response free
  assign do_write = aw_have_reg && w_have_reg && !o_bvalid;

  // Ready only while the slot is empty
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      o_awready   <= 1'b0;
      o_wready    <= 1'b0;
    end
    else if (i_clk_en)
    begin
      // Address taken
      if (o_awready && i_awvalid)
      begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= i_awaddr;
      end
      else if (do_write)
        aw_have_reg <= 1'b0;
      // Data taken
      if (o_wready && i_wvalid)
      begin
        w_have_reg <= 1'b1;
        w_data_reg <= i_wdata;
        w_strb_reg <= i_wstrb;
      end
      else if (do_write)
        w_have_reg <= 1'b0;
      // Registered readies; dropped on take so each channel takes one item
      o_awready <= !(aw_have_reg || (o_awready && i_awvalid)) || do_write;
      o_wready  <= !(w_have_reg || (o_wready && i_wvalid)) || do_write;
    end
  end

  // Write response
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_bvalid <= 1'b0;
      o_bresp  <= RESP_OKAY;
    end
    else if (i_clk_en)
    begin
      if (do_write)
      begin
        o_bvalid <= 1'b1;
        o_bresp  <= addr_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (o_bvalid && i_bready)
        o_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port control registers
  logic wr_byte0;                           // Low byte lane written
  logic wr_byte1;                           // Second byte lane written
  assign wr_byte0 = do_write && w_strb_reg[0];
  assign wr_byte1 = do_write && w_strb_reg[1];

  // Latch next value: direct write or toggle through input register
  logic [PORT_WIDTH-1:0] latch_next;        // pin_output_latch_bit after this edge
  always_comb
  begin
    latch_next = latch_reg;
    if (wr_byte0 && aw_addr_reg == OUTPUT_REG_ADDR)
      latch_next = w_data_reg[7:0];
    else if (wr_byte0 && aw_addr_reg == INPUT_REG_ADDR)
      latch_next = latch_reg ^ w_data_reg[7:0];
  end

  // Latch register
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      latch_reg <= PORT_RESET;
    else if (i_clk_en)
      latch_reg <= latch_next;
  end

  // Direction register; whole-byte write with per-bit effect only on changed bits
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      dir_reg <= PORT_RESET;
    else if (i_clk_en && wr_byte0 && aw_addr_reg == DIRECTION_REG_ADDR)
      dir_reg <= w_data_reg[7:0];
  end

  // Control bit and drive override
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pud_reg     <= 1'b0;
      ovr_en_reg  <= PORT_RESET;
      ovr_val_reg <= PORT_RESET;
    end
    else if (i_clk_en)
    begin
      if (wr_byte0 && aw_addr_reg == MCU_CONTROL_ADDR)
        pud_reg <= w_data_reg[PUD_BIT];
      if (wr_byte0 && aw_addr_reg == OVERRIDE_REG_ADDR)
        ovr_en_reg <= w_data_reg[7:0];
      if (wr_byte1 && aw_addr_reg == OVERRIDE_REG_ADDR)
        ovr_val_reg <= w_data_reg[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad drivers, registered; reset clears them at once with no clock
  logic [PORT_WIDTH-1:0] oe_next;           // Output driver enable
  logic [PORT_WIDTH-1:0] pu_next;           // Pull-up enable
  always_comb
  begin
    // Override acts per pin, so other pins keep plain behaviour
    oe_next = (ovr_en_reg & ovr_val_reg) | (~ovr_en_reg & dir_reg);
    pu_next = ~oe_next & latch_reg & {PORT_WIDTH{~pud_reg}};
  end

  // Enables lag the registers by one edge; the pad level loads with the latch
  // itself, so a written value reaches the sample exactly one cycle later
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_pad_oe    <= '0;
      o_pad       <= '0;
      o_pullup_en <= '0;
    end
    else if (i_clk_en)
    begin
      o_pad_oe    <= oe_next;
      o_pad       <= latch_next;
      o_pullup_en <= pu_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input path: clamp then half-cycle latch and rising flop
  logic [PORT_WIDTH-1:0] clamp_mask;        // Pins grounded while asleep
  logic [PORT_WIDTH-1:0] pad_in;            // Digital input after clamp
  assign clamp_mask = {PORT_WIDTH{i_input_clamp_request}} & ~i_ext_irq_enabled;
  assign pad_in     = i_pad & ~clamp_mask;

  // Latch transparent while clock is high, holds while low
  always_latch
  begin
    if (i_clock)
      sync_latch <= pad_in;
  end

  // Second stage; only this flop reads the latch
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      sample_reg <= '0;
    else if (i_clk_en)
      sample_reg <= sync_latch;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake flags: clamp release on a high edge-sensed disabled pad
  logic [PORT_WIDTH-1:0] wake_set;          // Flag set events
  logic [PORT_WIDTH-1:0] wake_clr;          // Software clear
  // Judged one edge after release: clamped pins sample low until then
  assign wake_set = {PORT_WIDTH{release_reg}} &
                    ~i_ext_irq_enabled & i_ext_irq_edge_sense & sample_reg;
  assign wake_clr = (wr_byte0 && aw_addr_reg == WAKE_FLAG_ADDR) ? w_data_reg[7:0] : '0;

  // Set wins over a clear in the same cycle
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wake_reg    <= '0;
      clamp_reg   <= 1'b0;
      release_reg <= 1'b0;
      o_wake_flag <= '0;
    end
    else if (i_clk_en)
    begin
      clamp_reg   <= i_input_clamp_request;
      release_reg <= clamp_reg & ~i_input_clamp_request;
      wake_reg    <= (wake_reg & ~wake_clr) | wake_set;
      o_wake_flag <= (wake_reg & ~wake_clr) | wake_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one read at a time
  logic [31:0] rd_mux;                      // Read data select
  always_comb
  begin
    rd_mux = '0;
    unique case (i_araddr)
      OUTPUT_REG_ADDR:    rd_mux[7:0] = latch_reg;
      DIRECTION_REG_ADDR: rd_mux[7:0] = dir_reg;
      INPUT_REG_ADDR:     rd_mux[7:0] = sample_reg;
      MCU_CONTROL_ADDR:   rd_mux[PUD_BIT] = pud_reg;
      OVERRIDE_REG_ADDR:  rd_mux[15:0] = {ovr_val_reg, ovr_en_reg};
      WAKE_FLAG_ADDR:     rd_mux[7:0] = wake_reg;
      default:            rd_mux = '0;
    endcase
  end

  // Address taken in the cycle arready is high; data next cycle
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= RESP_OKAY;
    end
    else if (i_clk_en)
    begin
      if (o_arready && i_arvalid)
      begin
        o_arready <= 1'b0;
        o_rvalid  <= 1'b1;
        o_rdata   <= rd_mux;
        o_rresp   <= addr_mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (o_rvalid)
      begin
        if (i_rready)
        begin
          o_rvalid  <= 1'b0;
          o_arready <= 1'b1;
        end
      end
      else
        o_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_DRIVE_FOLLOWS_DIR: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_clk_en |=> o_pad_oe == $past(oe_next)) else $error("Output enable wrong");
  AST_PAD_LEVEL: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_clk_en |=> o_pad == $past(latch_next)) else $error("Pad level wrong");
  AST_WRITE_RESP: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_clk_en && do_write |=> o_bvalid) else $error("Write response missing");
  AST_READ_RESP: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_clk_en && o_arready && i_arvalid |=> o_rvalid) else $error("Read response missing");
  AST_PULLUP_RULE: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_clk_en && !pud_reg |=> o_pullup_en == $past(~oe_next & latch_reg)) else $error("Pull-up wrong");
  AST_PULLUP_OFF_OUT: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (o_pullup_en & o_pad_oe) == '0) else $error("Pull-up on driven pad");
  AST_PUD_KILLS: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_clk_en && pud_reg |=> o_pullup_en == '0) else $error("Pull-up despite disable");
  AST_TOGGLE: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_clk_en && wr_byte0 && aw_addr_reg == INPUT_REG_ADDR |=>
    latch_reg == ($past(latch_reg) ^ $past(w_data_reg[7:0]))) else $error("Toggle failed");
  AST_PUD_BIT: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_clk_en && wr_byte0 && aw_addr_reg == MCU_CONTROL_ADDR |=> pud_reg == $past(w_data_reg[PUD_BIT]))
    else $error("Control bit not stored");
  AST_OVERRIDE: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_clk_en && (ovr_en_reg != '0) |=> ((o_pad_oe ^ $past(ovr_val_reg)) & $past(ovr_en_reg)) == '0)
    else $error("Override ignored");
  AST_WAKE_FLAG: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_clk_en && wake_set != '0 |=> (wake_reg & $past(wake_set)) == $past(wake_set))
    else $error("Wake flag missing");

  COV_WRITE: cover property (@(posedge i_clock) disable iff (!i_arst_n) do_write);
  COV_READ: cover property (@(posedge i_clock) disable iff (!i_arst_n) o_rvalid && i_rready);
  COV_WAKE: cover property (@(posedge i_clock) disable iff (!i_arst_n) wake_set != '0);
  COV_PULLUP: cover property (@(posedge i_clock) disable iff (!i_arst_n) o_pullup_en != '0);
  COV_TOGGLE: cover property (@(posedge i_clock) disable iff (!i_arst_n) wr_byte0 && aw_addr_reg == INPUT_REG_ADDR);

endmodule : gpp_port

// ---- dv/gpp_pad_model.sv ----
// Model of the external circuitry standing at the port's pads
`timescale 1ns/100ps
module gpp_pad_model
  import gpp_pkg::*;
(
  input  wire logic [PORT_WIDTH-1:0] i_drive,
  input  wire logic [PORT_WIDTH-1:0] i_drive_oe,
  input  wire logic [PORT_WIDTH-1:0] i_pullup_en,
  input  wire logic [PORT_WIDTH-1:0] i_ext_en,
  input  wire logic [PORT_WIDTH-1:0] i_ext_val,
  input  wire logic                  i_clock,
  output logic      [PORT_WIDTH-1:0] o_level
);
  logic [PORT_WIDTH-1:0] float_reg = 8'h55;  // Level of an undriven pad

  ////////////////////////////////////////////////////////////////////////////
  // Floating pads wander every cycle, so a stale value never reads as valid
  always @(posedge i_clock)
  begin
    float_reg <= ~float_reg;
  end

  // Device driver wins, then an outside driver, then the pull-up
  always_comb
  begin
    for (int n = 0; n < PORT_WIDTH; n++)
    begin
      if (i_drive_oe[n])
        o_level[n] = i_drive[n];
      else if (i_ext_en[n])
        o_level[n] = i_ext_val[n];
      else if (i_pullup_en[n])
        o_level[n] = 1'b1;
      else
        o_level[n] = float_reg[n];
    end
  end
endmodule : gpp_pad_model

// ---- dv/tb.sv ----
// Self-checking bench for the GPIO port
`timescale 1ns/100ps
module tb;
  import gpp_pkg::*;
  logic        i_clock  = 1'b0;          // 250 MHz
  logic        i_arst_n = 1'b0;          // Reset held at start
  logic [4:0]  awaddr   = '0;
  logic        awvalid  = 1'b0;
  logic [31:0] wdata    = '0;
  logic        wvalid   = 1'b0;
  logic        bready   = 1'b0;
  logic [4:0]  araddr   = '0;
  logic        arvalid  = 1'b0;
  logic        rready   = 1'b0;
  logic        clamp    = 1'b0;          // Sleep clamp request
  logic [7:0]  irq_en   = '0;            // Exempt pins
  logic [7:0]  edge_sn  = '0;            // Edge-sensed pins
  logic [7:0]  ext_en   = '0;            // Outside driver active
  logic [7:0]  ext_val  = '0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, exp_b;
  logic [31:0] rdata;
  logic [33:0] exp_r;
  logic [7:0]  pad_out, pad_oe, pull_en, wake, pad_level, dir, lat, m;
  logic [1:0]  bq[$];                    // Expected write responses
  logic [33:0] rq[$];                    // Expected read response and data
  int          n_mismatch = 0;
  int          cmp_count  = 0;
  logic [15:0] seed = 16'h6982;          // Fixed random start

  always #2 i_clock = ~i_clock;

  gpp_port dut (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_clk_en(1'b1), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .i_pad(pad_level), .o_pad(pad_out), .o_pad_oe(pad_oe), .o_pullup_en(pull_en),
    .i_input_clamp_request(clamp), .i_ext_irq_enabled(irq_en), .i_ext_irq_edge_sense(edge_sn),
    .o_wake_flag(wake));

  gpp_pad_model pads (.i_drive(pad_out), .i_drive_oe(pad_oe), .i_pullup_en(pull_en), .i_ext_en(ext_en),
    .i_ext_val(ext_val), .i_clock(i_clock), .o_level(pad_level));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic end_of_test;
    if (n_mismatch == 0 && cmp_count > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // Direct look at pad outputs, taken mid-cycle where they are settled
  task automatic chk8(input logic [7:0] act, input logic [7:0] exp, input string what);
    cmp_count++;
    if (act !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t %s got %h want %h", $time, what, act, exp);
    end
  endtask : chk8

  // Write: address and data offered together, each dropped once taken
  task automatic axw(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
    bit done;
    done = 1'b0;
    @(posedge i_clock);
    bq.push_back(r);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int k = 0; k < 40 && !done; k++)
    begin
      @(posedge i_clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) done = 1'b1;
    end
    bready <= 1'b0;
    if (!done)
    begin
      n_mismatch++;
      $display("BAD %0t write hang", $time);
      end_of_test();
    end
  endtask : axw

  // Read: expected word noted first, the watcher compares it
  task automatic axr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
    bit done;
    done = 1'b0;
    @(posedge i_clock);
    rq.push_back({r, d});
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int k = 0; k < 40 && !done; k++)
    begin
      @(posedge i_clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) done = 1'b1;
    end
    rready <= 1'b0;
    if (!done)
    begin
      n_mismatch++;
      $display("BAD %0t read hang", $time);
      end_of_test();
    end
  endtask : axr

  // Watcher: each response taken off the bus meets the oldest note
  always @(posedge i_clock)
  begin
    if (bvalid && bready)
    begin
      exp_b = (bq.size() > 0) ? bq.pop_front() : 2'bxx;
      cmp_count++;
      if (bresp !== exp_b)
      begin
        n_mismatch++;
        $display("BAD %0t bresp %h", $time, bresp);
      end
    end
    if (rvalid && rready)
    begin
      exp_r = (rq.size() > 0) ? rq.pop_front() : 'x;
      cmp_count++;
      if ({rresp, rdata} !== exp_r)
      begin
        n_mismatch++;
        $display("BAD %0t rdata %h want %h", $time, rdata, exp_r[31:0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge i_clock);
    i_arst_n <= 1'b1;
    @(negedge i_clock);
    chk8(pad_oe, 8'h00, "reset oe");
    chk8(pull_en, 8'h00, "reset pullup");
    axr(OUTPUT_REG_ADDR, 32'h0, RESP_OKAY);
    axr(DIRECTION_REG_ADDR, 32'h0, RESP_OKAY);
    // Random set-ups, always via tri-state so no forbidden step occurs
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      lat  = seed[7:0];
      dir  = seed[15:8];
      axw(DIRECTION_REG_ADDR, 32'h0, RESP_OKAY);
      axw(OUTPUT_REG_ADDR, 32'h0, RESP_OKAY);
      axw(OUTPUT_REG_ADDR, {24'h0, lat}, RESP_OKAY);
      axw(DIRECTION_REG_ADDR, {24'h0, dir}, RESP_OKAY);
      seed = lfsr(seed);
      ext_en  <= ~dir;
      ext_val <= seed[7:0];
      repeat (3) @(posedge i_clock);
      @(negedge i_clock);
      chk8(pad_oe, dir, "oe");
      chk8(pad_out & dir, lat & dir, "drive");
      chk8(pull_en, ~dir & lat, "pullup");
      axr(DIRECTION_REG_ADDR, {24'h0, dir}, RESP_OKAY);
      axr(INPUT_REG_ADDR, {24'h0, (dir & lat) | (~dir & seed[7:0])}, RESP_OKAY);
      m = seed[15:8];
      axw(INPUT_REG_ADDR, {24'h0, m}, RESP_OKAY);
      lat = lat ^ m;
      axr(OUTPUT_REG_ADDR, {24'h0, lat}, RESP_OKAY);
    end
    // All inputs with pull-ups, then the global switch
    axw(DIRECTION_REG_ADDR, 32'h0, RESP_OKAY);
    axw(OUTPUT_REG_ADDR, 32'hff, RESP_OKAY);
    axw(MCU_CONTROL_ADDR, 32'h10, RESP_OKAY);
    @(negedge i_clock);
    chk8(pull_en, 8'h00, "pud on");
    axr(MCU_CONTROL_ADDR, 32'h10, RESP_OKAY);
    axw(MCU_CONTROL_ADDR, 32'h0, RESP_OKAY);
    axw(OVERRIDE_REG_ADDR, 32'ha53c, RESP_OKAY);
    @(negedge i_clock);
    chk8(pad_oe, 8'h24, "override oe");
    chk8(pull_en, 8'hdb, "other pins");
    axw(OVERRIDE_REG_ADDR, 32'h0, RESP_OKAY);
    axw(5'h18, 32'hff, RESP_SLVERR);
    axr(5'h18, 32'h0, RESP_SLVERR);
    // Sleep clamp with half the pins exempt, then wake
    ext_en  <= 8'hff;
    ext_val <= 8'hff;
    irq_en  <= 8'h0f;
    edge_sn <= 8'hf0;
    clamp   <= 1'b1;
    repeat (3) @(posedge i_clock);
    axr(INPUT_REG_ADDR, 32'h0f, RESP_OKAY);
    clamp <= 1'b0;
    repeat (3) @(posedge i_clock);
    @(negedge i_clock);
    chk8(wake, 8'hf0, "wake");
    axw(WAKE_FLAG_ADDR, 32'hff, RESP_OKAY);
    axr(WAKE_FLAG_ADDR, 32'h0, RESP_OKAY);
    // Reset in mid-run with outputs and pull-ups active
    ext_en <= 8'hf0;
    axw(DIRECTION_REG_ADDR, 32'h0f, RESP_OKAY);
    @(posedge i_clock);
    i_arst_n <= 1'b0;
    #1;
    chk8(pad_oe, 8'h00, "async oe");
    chk8(pull_en, 8'h00, "async pullup");
    end_of_test();
  end
endmodule : tb
